//--- rtad_pkg.sv
// constants for the terminal address decode and host line block
// assumes a 16-bit received command word laid out with address lines 0..10 in its low bits
package rtad_pkg;

    // ************************************************************
    // word and field layout
    // ************************************************************
    localparam int RTAD_WORD_W = 16;
    localparam int RTAD_TA_W = 5;
    localparam int RTAD_WC_W = 5;
    localparam int RTAD_TA_MSB = 15;
    localparam int RTAD_TA_LSB = 11;
    localparam int RTAD_MODE_MSB = 10;
    localparam int RTAD_MODE_LSB = 6;
    localparam int RTAD_SA_TOP = 9;
    localparam int RTAD_SA_MID = 7;
    localparam int RTAD_SA_LOW = 5;
    localparam int RTAD_WC_UPPER = 3;
    localparam int RTAD_WC_LOWER = 1;

    // ************************************************************
    // values
    // ************************************************************
    localparam logic [RTAD_TA_W-1:0] RTAD_BCAST_ADDR = 5'h1F;
    localparam logic [RTAD_TA_W-1:0] RTAD_MODE_ONES = 5'h1F;
    localparam logic [RTAD_TA_W-1:0] RTAD_MODE_ZERO = 5'h00;
    localparam logic [RTAD_WORD_W-1:0] RTAD_WORD_ZERO = 16'h0000;
    localparam logic [RTAD_WC_W-1:0] RTAD_CNT_ZERO = 5'h00;
    localparam logic [RTAD_WC_W-1:0] RTAD_CNT_ONE = 5'h01;

    // ************************************************************
    // host bus transfer states
    // ************************************************************
    typedef enum logic [0:0]
    {
        RTAD_ST_IDLE = 1'b0,
        RTAD_ST_CMD = 1'b1
    } rtad_state_t;

endpackage

//--- rtad_parity.sv
// odd parity checker over a data field plus its parity bit
// assumes inputs are steady strap levels
`timescale 1ns/1ps
`default_nettype none

module rtad_parity #(
    parameter int WIDTH = 5
) (
    // checked field
    input wire logic [WIDTH-1:0] data_in,
    input wire logic parity_in,
    // result
    output logic odd_ok_out
);

    // odd count of ones over field and parity bit is good
    assign odd_ok_out = ^{data_in, parity_in};

endmodule
`default_nettype wire

//--- rtad_top.sv
// terminal address decode, latched command address lines and host bus lines
// assumes the protocol core hands over each valid received command word as a one-cycle pulse
//
// How it works
// - subaddress top, middle and low bits held on latched outputs
// - sixteen-bit host bus, bit 15 msb, driven toward host, sampled from host on writes while not driving
// - broadcast allowed: terminal address all ones is a broadcast message
// - broadcast barred: address 31 answered only if strapped address is 31
// - strap parity error drives fault low, single-terminal commands ignored
// - under parity fault, broadcasts still answered when broadcast allowed
// - address lines six to ten all zero or all one means mode command
// - upper count output shows latched word count bit when idle or mode
// - upper count output shows live counter bit when servicing data command
// - lower count output shows latched word count bit when idle or mode
// - lower count output shows live counter bit when servicing data command
// - servicing output high while a received command is processed
// - word kind select low for command word, high for data words
`timescale 1ns/1ps
`default_nettype none

module rtad_top
    import rtad_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK_IN,
    input wire logic SYS_RST_IN,
    // received command word from protocol core
    input wire logic CMD_VALID_IN,
    input wire logic [rtad_pkg::RTAD_WORD_W-1:0] CMD_WORD_IN,
    input wire logic MSG_DONE_IN,
    input wire logic WORD_ADVANCE_IN,
    // data words toward host
    input wire logic DATA_XFER_IN,
    input wire logic [rtad_pkg::RTAD_WORD_W-1:0] DATA_WORD_IN,
    // data words from host
    input wire logic HOST_WRITE_IN,
    output logic [rtad_pkg::RTAD_WORD_W-1:0] HOST_WORD_OUT,
    // straps and enables
    input wire logic BROADCAST_ALLOW_IN,
    input wire logic [rtad_pkg::RTAD_TA_W-1:0] OWN_TERM_ADDR_IN,
    input wire logic OWN_TERM_ADDR_PARITY_IN,
    // host data bus pins
    input wire logic [rtad_pkg::RTAD_WORD_W-1:0] HOST_BUS_IN,
    output logic [rtad_pkg::RTAD_WORD_W-1:0] HOST_BUS_OUT,
    output logic HOST_BUS_OE_N_OUT,
    // host address and status lines
    output logic SUBADDR_TOP_OUT,
    output logic SUBADDR_MID_OUT,
    output logic SUBADDR_LOW_OUT,
    output logic COUNT_MUX_UPPER_OUT,
    output logic COUNT_MUX_LOWER_OUT,
    output logic SERVICING_COMMAND_OUT,
    output logic WORD_KIND_SELECT_OUT,
    output logic TERM_ADDR_PARITY_FAULT_N_OUT,
    output logic CMD_ACCEPT_OUT,
    output logic BROADCAST_MSG_OUT
);

    import rtad_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    logic [RTAD_WORD_W-1:0] cmd_word;
    logic [RTAD_WC_W-1:0] word_count;
    logic servicing_command;
    logic parity_fault;
    logic broadcast_msg;
    logic [RTAD_WORD_W-1:0] bus_word;
    logic bus_drive;
    logic word_kind_select;
    logic [RTAD_WORD_W-1:0] host_word;
    rtad_state_t state;
    rtad_state_t next_state;
    logic parity_ok;
    wire logic [RTAD_TA_W-1:0] rx_addr;
    wire logic addr_match;
    wire logic addr_bcast;
    wire logic accept;
    wire logic [RTAD_TA_W-1:0] mode_lines;
    wire logic is_mode;
    wire logic use_live;

    // ************************************************************
    // strap parity check
    // ************************************************************
    rtad_parity #(.WIDTH(RTAD_TA_W)) u_rtad_parity (
        .data_in(OWN_TERM_ADDR_IN),
        .parity_in(OWN_TERM_ADDR_PARITY_IN),
        .odd_ok_out(parity_ok)
    );

    // parity fault register, low output on fault
    always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            parity_fault <= 1'b0;
        else
            parity_fault <= ~parity_ok;
    end

    // ************************************************************
    // address decode
    // ************************************************************
    assign rx_addr = CMD_WORD_IN[RTAD_TA_MSB:RTAD_TA_LSB];
    assign addr_match = (rx_addr == OWN_TERM_ADDR_IN) && !parity_fault;
    assign addr_bcast = BROADCAST_ALLOW_IN && (rx_addr == RTAD_BCAST_ADDR);
    assign accept = CMD_VALID_IN && (addr_match || addr_bcast);

    // mode command decode on the latched address lines
    assign mode_lines = cmd_word[RTAD_MODE_MSB:RTAD_MODE_LSB];
    assign is_mode = (mode_lines == RTAD_MODE_ZERO) || (mode_lines == RTAD_MODE_ONES);
    assign use_live = servicing_command && !is_mode;

    // ************************************************************
    // command latch, message state and word counter
    // ************************************************************
    always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            cmd_word <= RTAD_WORD_ZERO;
            broadcast_msg <= 1'b0;
        end
        else if (accept)
        begin
            cmd_word <= CMD_WORD_IN;
            broadcast_msg <= addr_bcast;
        end
    end

    // servicing flag: new command restarts, done ends
    always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            servicing_command <= 1'b0;
        else if (accept)
            servicing_command <= 1'b1;
        else if (MSG_DONE_IN)
            servicing_command <= 1'b0;
    end

    // live word counter
    always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            word_count <= RTAD_CNT_ZERO;
        else if (accept)
            word_count <= RTAD_CNT_ZERO;
        else if (servicing_command && WORD_ADVANCE_IN)
            word_count <= word_count + RTAD_CNT_ONE;
    end

    // ************************************************************
    // host bus transfer
    // ************************************************************
    always_comb
    begin
        next_state = RTAD_ST_IDLE;
        case (state)
            RTAD_ST_IDLE: next_state = accept ? RTAD_ST_CMD : RTAD_ST_IDLE;
            RTAD_ST_CMD: next_state = accept ? RTAD_ST_CMD : RTAD_ST_IDLE;
            default: next_state = RTAD_ST_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            state <= RTAD_ST_IDLE;
        else
            state <= next_state;
    end

    // bus word and drive: command word first, then data words
    always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            bus_word <= RTAD_WORD_ZERO;
            bus_drive <= 1'b0;
            word_kind_select <= 1'b1;
        end
        else if (accept)
        begin
            bus_word <= CMD_WORD_IN;
            bus_drive <= 1'b1;
            word_kind_select <= 1'b0;
        end
        else if (DATA_XFER_IN && state == RTAD_ST_IDLE)
        begin
            bus_word <= DATA_WORD_IN;
            bus_drive <= 1'b1;
            word_kind_select <= 1'b1;
        end
        else
        begin
            bus_drive <= 1'b0;
            word_kind_select <= 1'b1;
        end
    end

    // words written by host, sampled only while not driving
    always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            host_word <= RTAD_WORD_ZERO;
        else if (HOST_WRITE_IN && !bus_drive)
            host_word <= HOST_BUS_IN;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign SUBADDR_TOP_OUT = cmd_word[RTAD_SA_TOP];
    assign SUBADDR_MID_OUT = cmd_word[RTAD_SA_MID];
    assign SUBADDR_LOW_OUT = cmd_word[RTAD_SA_LOW];
    assign COUNT_MUX_UPPER_OUT = use_live ? word_count[RTAD_WC_UPPER] : cmd_word[RTAD_WC_UPPER];
    assign COUNT_MUX_LOWER_OUT = use_live ? word_count[RTAD_WC_LOWER] : cmd_word[RTAD_WC_LOWER];
    assign SERVICING_COMMAND_OUT = servicing_command;
    assign WORD_KIND_SELECT_OUT = word_kind_select;
    assign TERM_ADDR_PARITY_FAULT_N_OUT = ~parity_fault;
    assign CMD_ACCEPT_OUT = accept;
    assign BROADCAST_MSG_OUT = broadcast_msg;
    assign HOST_BUS_OUT = bus_word;
    assign HOST_BUS_OE_N_OUT = ~bus_drive;
    assign HOST_WORD_OUT = host_word;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    sequence accept_seq;
        CMD_VALID_IN && accept;
    endsequence

    sequence cmd_on_bus_seq;
        !HOST_BUS_OE_N_OUT && !WORD_KIND_SELECT_OUT && SERVICING_COMMAND_OUT;
    endsequence

    subaddr_latch_a: assert property (accept_seq |=> SUBADDR_TOP_OUT == $past(CMD_WORD_IN[RTAD_SA_TOP])
        && SUBADDR_LOW_OUT == $past(CMD_WORD_IN[RTAD_SA_LOW]))
        else $error("subaddress lines not latched");
    bus_dir_a: assert property (!HOST_BUS_OE_N_OUT |-> $past(accept) || $past(DATA_XFER_IN))
        else $error("host bus driven without transfer");
    bcast_take_a: assert property (CMD_VALID_IN && BROADCAST_ALLOW_IN && rx_addr == RTAD_BCAST_ADDR
        |=> BROADCAST_MSG_OUT && SERVICING_COMMAND_OUT)
        else $error("broadcast not taken");
    bcast_bar_a: assert property (CMD_VALID_IN && !BROADCAST_ALLOW_IN && rx_addr == RTAD_BCAST_ADDR
        && OWN_TERM_ADDR_IN != RTAD_BCAST_ADDR |-> !CMD_ACCEPT_OUT)
        else $error("address 31 answered while barred");
    fault_ignore_a: assert property (!TERM_ADDR_PARITY_FAULT_N_OUT && CMD_VALID_IN
        && rx_addr != RTAD_BCAST_ADDR |-> !CMD_ACCEPT_OUT)
        else $error("single-terminal command taken under fault");
    fault_bcast_a: assert property (!TERM_ADDR_PARITY_FAULT_N_OUT && CMD_VALID_IN && BROADCAST_ALLOW_IN
        && rx_addr == RTAD_BCAST_ADDR |-> CMD_ACCEPT_OUT)
        else $error("broadcast lost under fault");
    count_upper_a: assert property (SERVICING_COMMAND_OUT && !is_mode
        |-> COUNT_MUX_UPPER_OUT == word_count[RTAD_WC_UPPER])
        else $error("upper count line not live");
    count_lower_a: assert property (!SERVICING_COMMAND_OUT || is_mode
        |-> COUNT_MUX_LOWER_OUT == cmd_word[RTAD_WC_LOWER])
        else $error("lower count line not latched");
    servicing_hold_a: assert property (accept_seq ##1 (!MSG_DONE_IN && !accept) [*3]
        |-> SERVICING_COMMAND_OUT)
        else $error("servicing dropped early");
    cmd_kind_a: assert property (accept_seq |=> cmd_on_bus_seq
        ##0 HOST_BUS_OUT == $past(CMD_WORD_IN))
        else $error("command word not shown with low kind select");
    parity_fault_a: assert property (parity_ok |=> TERM_ADDR_PARITY_FAULT_N_OUT)
        else $error("fault raised with good parity");

endmodule
`default_nettype wire

//--- rtad_host_model.sv
// host subsystem model: straps the own terminal address and shares the data bus
// assumes the device enable is active low and the bus has no pull resistors
`timescale 1ns/1ps
`default_nettype none

module rtad_host_model (
    // clock
    input wire logic clk_in,
    // device side of the bus
    input wire logic dev_oe_n_in,
    input wire logic [15:0] dev_word_in,
    // host stimulus
    input wire logic host_en_in,
    input wire logic [15:0] host_word_in,
    input wire logic [4:0] strap_in,
    input wire logic bad_par_in,
    // levels seen by the device
    output logic [15:0] bus_out,
    output logic [4:0] strap_out,
    output logic strap_par_out
);
    logic [15:0] last;
    // undriven bus drifts away from its last level
    always_ff @(posedge clk_in)
    begin
        last <= bus_out;
    end
    // host drives only while the device has let go of the bus
    assign bus_out = !dev_oe_n_in ? dev_word_in : (host_en_in ? host_word_in : ~last);
    // own address strapped msb first, odd parity unless a fault is wanted
    assign strap_out = strap_in;
    assign strap_par_out = (~^strap_in) ^ bad_par_in;
endmodule
`default_nettype wire

//--- test_rtad_top.sv
// testbench for the address decode block: random messages, queued expectations
// assumes the host model owns the bus and straps; inputs change on falling edges
`timescale 1ns/1ps
`default_nettype none

module test_rtad_top;
    import rtad_pkg::*;
    typedef struct packed
    {
        int cyc;
        logic [42:0] e;
        logic [42:0] m;
    } rtad_note_t;
    logic clk, rst, cmd_valid, msg_done, adv, xfer, host_wr, allow, par, oe_n, acc, bcast, host_en, bad_par;
    logic sat, sam, sal, cu, cl, srv, kind, fault_n, s_e, lbc, lmd, a, b, md;
    logic [15:0] cmd_word, data_word, host_word, bus_in, bus_out, hdrv, lw, w;
    logic [4:0] strap, own, cnt;
    logic [31:0] seed, r;
    logic [42:0] ob;
    int cyc = 0;
    int err_total = 0;
    int n_tests = 0;
    rtad_note_t q[$];
    rtad_note_t nt;

    rtad_top u_rtad_top (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .CMD_VALID_IN(cmd_valid), .CMD_WORD_IN(cmd_word),
        .MSG_DONE_IN(msg_done), .WORD_ADVANCE_IN(adv), .DATA_XFER_IN(xfer), .DATA_WORD_IN(data_word),
        .HOST_WRITE_IN(host_wr), .HOST_WORD_OUT(host_word), .BROADCAST_ALLOW_IN(allow), .OWN_TERM_ADDR_IN(own),
        .OWN_TERM_ADDR_PARITY_IN(par), .HOST_BUS_IN(bus_in), .HOST_BUS_OUT(bus_out), .HOST_BUS_OE_N_OUT(oe_n),
        .SUBADDR_TOP_OUT(sat), .SUBADDR_MID_OUT(sam), .SUBADDR_LOW_OUT(sal), .COUNT_MUX_UPPER_OUT(cu),
        .COUNT_MUX_LOWER_OUT(cl), .SERVICING_COMMAND_OUT(srv), .WORD_KIND_SELECT_OUT(kind),
        .TERM_ADDR_PARITY_FAULT_N_OUT(fault_n), .CMD_ACCEPT_OUT(acc), .BROADCAST_MSG_OUT(bcast));
    rtad_host_model u_rtad_host_model (.clk_in(clk), .dev_oe_n_in(oe_n), .dev_word_in(bus_out),
        .host_en_in(host_en), .host_word_in(hdrv), .strap_in(strap), .bad_par_in(bad_par), .bus_out(bus_in),
        .strap_out(own), .strap_par_out(par));
    // observed lines, packed in note order
    assign ob = {acc, srv, kind, oe_n, fault_n, bcast, sat, sam, sal, cu, cl, bus_out, host_word};

    // ************************************************************
    // clock, monitor and helpers
    // ************************************************************
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // compare every due note, oldest first, once its cycle has settled
    initial
    begin
        forever
        begin
            @(posedge clk);
            cyc = cyc + 1;
            #5;
            while (q.size() > 0 && q[0].cyc <= cyc)
            begin
                nt = q.pop_front();
                n_tests = n_tests + 1;
                if ((ob & nt.m) !== (nt.e & nt.m))
                begin
                    err_total = err_total + 1;
                    $display("BAD %0t lines %h expected %h", $time, ob & nt.m, nt.e & nt.m);
                end
            end
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task step(int n);
        repeat (n) @(negedge clk);
    endtask
    task note(logic [42:0] e, logic [42:0] m);
        q.push_back('{cyc + 1, e, m});
    endtask
    // address lines: latched word, or live count while a data command runs
    task lines(logic s);
        note({1'b0, s, 2'b11, 1'b0, lbc, lw[9], lw[7], lw[5], (s && !lmd) ? cnt[3] : lw[3],
            (s && !lmd) ? cnt[1] : lw[1], 32'h0000_0000}, 43'h3BF_0000_0000);
    endtask
    task complete_run();
        if (q.size() > 0)
            err_total = err_total + 1;
        if (err_total == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ************************************************************
    // one random message: straps, command, count, transfers, end
    // ************************************************************
    task run_msg();
        r = rnd();
        strap = r[4:0];
        bad_par = (r[7:5] == 3'h0);
        allow = r[8];
        w = r[31:16];
        if (r[10:9] == 2'h0)
            w[15:11] = r[4:0];
        if (r[10:9] == 2'h1)
            w[15:11] = 5'h1F;
        if (r[11])
            w[10:6] = {5{r[12]}};
        b = allow && w[15:11] == 5'h1F;
        a = b || (w[15:11] == r[4:0] && !bad_par);
        md = w[10:6] == 5'h00 || w[10:6] == 5'h1F;
        step(2);
        note({4'h0, !bad_par, 38'h0}, {4'h0, 1'b1, 38'h0});
        cmd_valid = 1'b1;
        cmd_word = w;
        // servicing rises with the latch, so a data command already shows the restarted live count
        note({a, 3'b100, !bad_par, b, w[9], w[7], w[5], md & w[3], md & w[1], w, 16'h0000},
            a ? 43'h7FF_FFFF_0000 : 43'h400_0000_0000);
        if (a)
        begin
            lw = w;
            lbc = b;
            lmd = md;
            cnt = 5'h00;
            s_e = 1'b1;
        end
        step(1);
        cmd_valid = 1'b0;
        lines(s_e);
        if (s_e)
        begin
            step(1);
            repeat ({r[15:13], 1'b1})
            begin
                adv = 1'b1;
                cnt = cnt + 5'h01;
                lines(1'b1);
                step(1);
            end
            adv = 1'b0;
            r = rnd();
            data_word = r[15:0];
            hdrv = r[31:16];
            xfer = 1'b1;
            note({4'b0110, 7'h00, r[15:0], 16'h0000}, {4'b0111, 7'h00, 16'hFFFF, 16'h0000});
            step(1);
            xfer = 1'b0;
            step(1);
            host_en = 1'b1;
            host_wr = 1'b1;
            note({27'h000_0000, r[31:16]}, {27'h000_0000, 16'hFFFF});
            step(1);
            host_wr = 1'b0;
            host_en = 1'b0;
            msg_done = 1'b1;
            s_e = 1'b0;
            lines(1'b0);
            step(1);
            msg_done = 1'b0;
        end
    endtask

    // main sequence: reset, reset values, random messages
    initial
    begin
        {rst, cmd_valid, msg_done, adv, xfer, host_wr, allow, host_en, bad_par, s_e, lbc, lmd} = 12'h800;
        cmd_word = 16'h0000;
        data_word = 16'h0000;
        hdrv = 16'h0000;
        lw = 16'h0000;
        strap = 5'h05;
        cnt = 5'h00;
        seed = 32'h0000_005E;
        repeat (10) @(posedge clk);
        step(1);
        rst = 1'b0;
        note({3'b001, 2'b11, 6'h00, 32'h0000_0000}, 43'h3FF_FFFF_0000);
        repeat (60) run_msg();
        step(3);
        complete_run();
    end
endmodule
`default_nettype wire
